// ---- hw/iso_rx_context_control.sv ----
`timescale 1ns/1ps
`include "iso_rx_ctx_regs.svh"

module iso_rx_context_control
  import iso_rx_ctx_pkg::*;
#(
  parameter int CONTEXT_INDEX = 0,
  parameter int DATA_WIDTH = 32,
  parameter int CHANNELS = 64
) (
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // cycle timer and match register
  input wire logic cycle_start,
  input wire logic [12:0] bus_cycle_number,
  input wire logic [12:0] start_cycle_value,
  input wire logic [5:0] match_channel,
  input wire logic [CHANNELS-1:0] channel_mask,
  // received packet stream from the link
  input wire logic pkt_start,
  input wire logic [5:0] pkt_channel,
  input wire logic [2:0] pkt_speed,
  input wire logic pkt_data_valid,
  input wire logic pkt_second_portion,
  input wire logic [DATA_WIDTH-1:0] pkt_data,
  input wire logic pkt_end,
  input wire pkt_status_type pkt_status,
  // descriptor engine
  input wire logic desc_fetch,
  input wire dma_err_type dma_err,
  input wire logic buf_full,
  // outputs to the buffer writer
  output logic fetch_enable,
  output logic header_keep,
  output logic buf_wr,
  output logic head_wr,
  output logic tail_wr,
  output logic [DATA_WIDTH-1:0] wr_data,
  output logic pkt_commit,
  output logic pkt_backout,
  output logic buf_close,
  output ctrl_type ctrl_view
);

  localparam logic [11:0] SET_ADDR =
    12'(`CTX_SET_OFFSET + `CTX_STRIDE * CONTEXT_INDEX);
  localparam logic [11:0] CLEAR_ADDR =
    12'(`CTX_CLEAR_OFFSET + `CTX_STRIDE * CONTEXT_INDEX);

  ctrl_type ctl;
  ctrl_type next_ctl;
  ctx_state_type state;
  ctx_state_type next_state;

  logic in_pkt;
  logic next_in_pkt;
  logic [2:0] pkt_spd;
  logic [2:0] next_pkt_spd;
  logic next_buf_wr;
  logic next_head_wr;
  logic next_tail_wr;
  logic [DATA_WIDTH-1:0] next_wr_data;
  logic next_pkt_commit;
  logic next_pkt_backout;
  logic next_buf_close;
  logic [31:0] next_reg_rdata;
  logic next_reg_rvalid;

  logic set_hit;
  logic clr_hit;
  logic [31:0] wr_set;
  logic [31:0] wr_clr;
  logic busy;
  logic running;
  logic cycle_match;
  logic pkt_done;
  logic channel_hit;
  logic chk_backout;
  logic chk_fatal;
  logic [4:0] chk_code;
  logic [31:0] ctrl_word;

  assign set_hit = reg_wr && (reg_addr == SET_ADDR);
  assign clr_hit = reg_wr && (reg_addr == CLEAR_ADDR);
  assign wr_set = set_hit ? reg_wdata : 32'h0000_0000;
  assign wr_clr = clr_hit ? reg_wdata : 32'h0000_0000;

  // mode bits other than cyc_en are frozen from the moment run is seen until the context idles
  assign busy = ctl.run | ctl.active;
  assign running = (state == ST_RUNNING);
  assign cycle_match = cycle_start && (bus_cycle_number == start_cycle_value);
  assign pkt_done = in_pkt && pkt_end;

  iso_rx_packet_check #(
    .CHANNELS(CHANNELS)
  ) u_check (
    .pkt_channel(pkt_channel),
    .match_channel(match_channel),
    .channel_mask(channel_mask),
    .all_channel_mode(ctl.all_ch),
    .packed_fill_mode(ctl.fill),
    .pkt_status(pkt_status),
    .dma_err(dma_err),
    .channel_hit(channel_hit),
    .backout(chk_backout),
    .fatal(chk_fatal),
    .completion_code(chk_code)
  );

  // reserved ranges 26:16, 14:13 and 9:8 are tied low
  assign ctrl_word = {ctl.fill, ctl.iso_hdr, ctl.cyc_en, ctl.all_ch, ctl.split,
                      11'h000, ctl.run, 2'h0, ctl.wake, ctl.dead, ctl.active,
                      2'h0, ctl.speed, ctl.code};

  always_comb begin
    next_ctl = ctl;
    next_state = state;
    if (!busy) begin
      next_ctl.fill = (ctl.fill | wr_set[`FILL_BIT]) & ~wr_clr[`FILL_BIT];
      next_ctl.iso_hdr = (ctl.iso_hdr | wr_set[`ISO_HDR_BIT]) & ~wr_clr[`ISO_HDR_BIT];
      next_ctl.cyc_en = (ctl.cyc_en | wr_set[`CYC_EN_BIT]) & ~wr_clr[`CYC_EN_BIT];
      next_ctl.all_ch = (ctl.all_ch | wr_set[`ALL_CH_BIT]) & ~wr_clr[`ALL_CH_BIT];
      next_ctl.split = (ctl.split | wr_set[`SPLIT_BIT]) & ~wr_clr[`SPLIT_BIT];
    end
    if (next_ctl.split) begin
      next_ctl.fill = 1'b0;
      next_ctl.all_ch = 1'b0;
    end
    // only software moves run; reset is the device's only say
    next_ctl.run = (ctl.run | wr_set[`RUN_BIT]) & ~wr_clr[`RUN_BIT];
    // a software set in the fetch cycle survives the clear
    next_ctl.wake = (ctl.wake & ~desc_fetch) | wr_set[`WAKE_BIT];
    case (state)
      ST_IDLE: begin
        if (next_ctl.run) begin
          if (next_ctl.cyc_en) begin
            next_state = ST_WAIT_CYCLE;
          end else begin
            next_state = ST_RUNNING;
          end
        end
      end
      ST_WAIT_CYCLE: begin
        if (!next_ctl.run) begin
          next_state = ST_IDLE;
        end else if (cycle_match) begin
          next_state = ST_RUNNING;
        end
      end
      ST_RUNNING: begin
        if (!next_ctl.run) begin
          next_state = ST_IDLE;
        end else if (chk_fatal) begin
          next_state = ST_HALTED;
        end
      end
      ST_HALTED: begin
        if (!next_ctl.run) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_ctl.active = (next_state == ST_RUNNING);
    if (next_state == ST_RUNNING && state != ST_RUNNING) begin
      next_ctl.cyc_en = 1'b0;
    end
    // a fatal error in the cycle run drops keeps dead set
    if (running && chk_fatal) begin
      next_ctl.dead = 1'b1;
      next_ctl.code = chk_code;
    end else if (ctl.run && !next_ctl.run) begin
      next_ctl.dead = 1'b0;
    end
    if (pkt_done && !(running && chk_fatal)) begin
      next_ctl.speed = pkt_spd;
      next_ctl.code = chk_code;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // the reset word is register-wide; the struct takes only its low 17 bits
      ctl <= ctrl_type'($bits(ctrl_type)'(`CTRL_RESET));
      state <= ST_IDLE;
    end else begin
      ctl <= next_ctl;
      state <= next_state;
    end
  end

  always_comb begin
    next_in_pkt = in_pkt;
    next_pkt_spd = pkt_spd;
    next_buf_wr = 1'b0;
    next_head_wr = 1'b0;
    next_tail_wr = 1'b0;
    next_wr_data = wr_data;
    next_pkt_commit = 1'b0;
    next_pkt_backout = 1'b0;
    next_buf_close = 1'b0;
    if (!running) begin
      // a halt mid-packet drops the rest of that packet
      next_in_pkt = 1'b0;
    end else if (pkt_start && channel_hit) begin
      next_in_pkt = 1'b1;
      // the link carries 100, 200 or 400 as 000, 001 or 010
      next_pkt_spd = pkt_speed;
    end else if (in_pkt) begin
      if (pkt_data_valid) begin
        next_wr_data = pkt_data;
        if (ctl.split) begin
          next_head_wr = ~pkt_second_portion;
          next_tail_wr = pkt_second_portion;
        end else begin
          next_buf_wr = 1'b1;
        end
      end
      if (pkt_end) begin
        next_in_pkt = 1'b0;
        next_pkt_backout = chk_backout;
        next_pkt_commit = ~chk_backout;
        // packet-per-buffer closes on every packet, packed fill only when full
        next_buf_close = ~ctl.fill;
      end
    end
    if (running && ctl.fill && buf_full) begin
      next_buf_close = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      in_pkt <= 1'b0;
      pkt_spd <= `SPEED_100;
      buf_wr <= 1'b0;
      head_wr <= 1'b0;
      tail_wr <= 1'b0;
      wr_data <= '0;
      pkt_commit <= 1'b0;
      pkt_backout <= 1'b0;
      buf_close <= 1'b0;
    end else begin
      in_pkt <= next_in_pkt;
      pkt_spd <= next_pkt_spd;
      buf_wr <= next_buf_wr;
      head_wr <= next_head_wr;
      tail_wr <= next_tail_wr;
      wr_data <= next_wr_data;
      pkt_commit <= next_pkt_commit;
      pkt_backout <= next_pkt_backout;
      buf_close <= next_buf_close;
    end
  end

  // both views read the same word; anything else reads zero
  always_comb begin
    next_reg_rvalid = reg_rd;
    next_reg_rdata = 32'h0000_0000;
    if (reg_rd && (reg_addr == SET_ADDR || reg_addr == CLEAR_ADDR)) begin
      next_reg_rdata = ctrl_word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

  assign fetch_enable = ctl.active;
  assign header_keep = ctl.iso_hdr;
  assign ctrl_view = ctl;

endmodule : iso_rx_context_control

// ---- hw/iso_rx_ctx_pkg.sv ----
package iso_rx_ctx_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_CYCLE,
    ST_RUNNING,
    ST_HALTED
  } ctx_state_type;

  typedef struct packed {
    logic fill;
    logic iso_hdr;
    logic cyc_en;
    logic all_ch;
    logic split;
    logic run;
    logic wake;
    logic dead;
    logic active;
    logic [2:0] speed;
    logic [4:0] code;
  } ctrl_type;

  typedef struct packed {
    logic len_mismatch;
    logic crc_error;
    logic overrun;
    logic too_long;
  } pkt_status_type;

  typedef struct packed {
    logic desc_read;
    logic data_write;
    logic unknown;
  } dma_err_type;

endpackage : iso_rx_ctx_pkg

// ---- hw/iso_rx_ctx_regs.svh ----
`ifndef ISO_RX_CTX_REGS_SVH
`define ISO_RX_CTX_REGS_SVH

// control register, set and clear views of context 0, stride per context
`define CTX_SET_OFFSET 12'h400
`define CTX_CLEAR_OFFSET 12'h404
`define CTX_STRIDE 12'h020

// control register field positions
`define FILL_BIT 31
`define ISO_HDR_BIT 30
`define CYC_EN_BIT 29
`define ALL_CH_BIT 28
`define SPLIT_BIT 27
`define RUN_BIT 15
`define WAKE_BIT 12
`define DEAD_BIT 11
`define ACTIVE_BIT 10
`define SPEED_MSB 7
`define SPEED_LSB 5
`define CODE_MSB 4
`define CODE_LSB 0

// reset value of the whole control word
`define CTRL_RESET 32'h0000_0000

// received speed codes
`define SPEED_100 3'h0
`define SPEED_200 3'h1
`define SPEED_400 3'h2

// completion codes
`define ACK_COMPLETE 5'h11
`define ACK_DATA_ERROR 5'h1D
`define EVT_LONG_PACKET 5'h03
`define EVT_OVERRUN 5'h05
`define EVT_DESCRIPTOR_READ 5'h06
`define EVT_DATA_WRITE 5'h08
`define EVT_UNKNOWN 5'h0E

`endif

// ---- hw/iso_rx_packet_check.sv ----
`timescale 1ns/1ps
`include "iso_rx_ctx_regs.svh"

module iso_rx_packet_check
  import iso_rx_ctx_pkg::*;
#(
  parameter int CHANNELS = 64
) (
  input wire logic [5:0] pkt_channel,
  input wire logic [5:0] match_channel,
  input wire logic [CHANNELS-1:0] channel_mask,
  input wire logic all_channel_mode,
  input wire logic packed_fill_mode,
  input wire pkt_status_type pkt_status,
  input wire dma_err_type dma_err,
  output logic channel_hit,
  output logic backout,
  output logic fatal,
  output logic [4:0] completion_code
);

  always_comb begin
    if (all_channel_mode) begin
      channel_hit = channel_mask[pkt_channel];
    end else begin
      channel_hit = (pkt_channel == match_channel);
    end
  end

  assign fatal = dma_err.desc_read | dma_err.data_write | dma_err.unknown;

  // packets with a length, CRC or overrun error in packed fill leave no trace in the buffer
  assign backout = packed_fill_mode &
    (pkt_status.len_mismatch | pkt_status.crc_error | pkt_status.overrun);

  always_comb begin
    if (dma_err.desc_read) begin
      completion_code = `EVT_DESCRIPTOR_READ;
    end else if (dma_err.data_write) begin
      completion_code = `EVT_DATA_WRITE;
    end else if (dma_err.unknown) begin
      completion_code = `EVT_UNKNOWN;
    end else if (packed_fill_mode) begin
      completion_code = `ACK_COMPLETE;
    end else if (pkt_status.overrun) begin
      completion_code = `EVT_OVERRUN;
    end else if (pkt_status.too_long) begin
      completion_code = `EVT_LONG_PACKET;
    end else if (pkt_status.len_mismatch | pkt_status.crc_error) begin
      completion_code = `ACK_DATA_ERROR;
    end else begin
      completion_code = `ACK_COMPLETE;
    end
  end

endmodule : iso_rx_packet_check

// ---- verif/desc_engine_model.sv ----
`timescale 1ns/1ps
module desc_engine_model
  import iso_rx_ctx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fetch_enable,
  input wire logic fetch_req,
  input wire logic slow,
  input wire dma_err_type err_req,
  output logic desc_fetch,
  output dma_err_type dma_err
);
  logic pend;
  // slow adds one cycle of memory latency before the fetch lands
  always_ff @(posedge clk) begin
    if (rst) begin
      pend <= 1'b0;
      desc_fetch <= 1'b0;
      dma_err <= '0;
    end else begin
      pend <= fetch_req && fetch_enable && slow;
      desc_fetch <= pend || (fetch_req && fetch_enable && !slow);
      dma_err <= err_req;
    end
  end
endmodule : desc_engine_model

// ---- verif/iso_rx_context_control_bench.sv ----
`timescale 1ns/1ps
`include "iso_rx_ctx_regs.svh"
module iso_rx_context_control_bench
  import iso_rx_ctx_pkg::*;
;
  logic clk, rst, reg_wr, reg_rd, reg_rvalid, cycle_start, pkt_start, pkt_data_valid;
  logic pkt_second_portion, pkt_end, buf_full, fetch_req, slow, desc_fetch, fetch_enable;
  logic header_keep, buf_wr, head_wr, tail_wr, pkt_commit, pkt_backout, buf_close;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, pkt_data, wr_data;
  logic [12:0] bus_cycle_number;
  logic [5:0] pkt_channel;
  logic [2:0] pkt_speed;
  logic [63:0] channel_mask;
  pkt_status_type pkt_status;
  dma_err_type dma_err, err_req;
  ctrl_type ctrl_view;
  int errors, tests_run;

  iso_rx_context_control i_iso_rx_context_control (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .cycle_start(cycle_start), .bus_cycle_number(bus_cycle_number),
    .start_cycle_value(13'h1ABC), .match_channel(6'h05), .channel_mask(channel_mask),
    .pkt_start(pkt_start), .pkt_channel(pkt_channel), .pkt_speed(pkt_speed),
    .pkt_data_valid(pkt_data_valid), .pkt_second_portion(pkt_second_portion),
    .pkt_data(pkt_data), .pkt_end(pkt_end), .pkt_status(pkt_status), .desc_fetch(desc_fetch),
    .dma_err(dma_err), .buf_full(buf_full), .fetch_enable(fetch_enable),
    .header_keep(header_keep), .buf_wr(buf_wr), .head_wr(head_wr), .tail_wr(tail_wr),
    .wr_data(wr_data), .pkt_commit(pkt_commit), .pkt_backout(pkt_backout),
    .buf_close(buf_close), .ctrl_view(ctrl_view));

  desc_engine_model i_desc_engine_model (
    .clk(clk), .rst(rst), .fetch_enable(fetch_enable), .fetch_req(fetch_req), .slow(slow),
    .err_req(err_req), .desc_fetch(desc_fetch), .dma_err(dma_err));

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", 32'h1, 32'(reg_rvalid));
    chk("rdata", e, reg_rdata);
  endtask : rd

  task automatic cyc(input logic [12:0] n);
    @(posedge clk);
    cycle_start <= 1'b1;
    bus_cycle_number <= n;
    @(posedge clk);
    cycle_start <= 1'b0;
    #1;
  endtask : cyc

  task automatic pkt(input logic [5:0] ch, input logic [2:0] sp, input pkt_status_type st,
      input logic sec, output logic [2:0] w, output logic [2:0] e);
    @(posedge clk);
    pkt_start <= 1'b1;
    pkt_channel <= ch;
    pkt_speed <= sp;
    @(posedge clk);
    pkt_start <= 1'b0;
    pkt_data_valid <= 1'b1;
    pkt_second_portion <= sec;
    @(posedge clk);
    pkt_data_valid <= 1'b0;
    pkt_end <= 1'b1;
    pkt_status <= st;
    #1;
    w = {buf_wr, head_wr, tail_wr};
    @(posedge clk);
    pkt_end <= 1'b0;
    #1;
    e = {pkt_commit, pkt_backout, buf_close};
  endtask : pkt

  task automatic t_reset;
    rd(`CTX_SET_OFFSET, `CTRL_RESET);
    rd(12'h7F0, 32'h0);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_run;
    logic [2:0] w;
    logic [2:0] e;
    wr(`CTX_SET_OFFSET, 32'hFFFF_FFFF);
    rd(`CTX_SET_OFFSET, 32'h6800_9000);
    chk("header_keep", 32'h1, 32'(header_keep));
    cyc(13'h0ABC);
    chk("early_start", 32'h0, 32'(ctrl_view.active));
    cyc(13'h1ABC);
    rd(`CTX_SET_OFFSET, 32'h4800_9400);
    wr(`CTX_CLEAR_OFFSET, 32'h0800_1000);
    rd(`CTX_SET_OFFSET, 32'h4800_9400);
    @(posedge clk);
    slow <= 1'b1;
    fetch_req <= 1'b1;
    @(posedge clk);
    fetch_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("wake", 32'h0, 32'(ctrl_view.wake));
    pkt(6'h05, `SPEED_400, '0, 1'b1, w, e);
    chk("split_wr", 32'h1, 32'(w));
    chk("wr_data", 32'h0000_00A5, wr_data);
    chk("split_end", 32'h5, 32'(e));
    chk("spd_code", {`SPEED_400, `ACK_COMPLETE}, 32'({ctrl_view.speed, ctrl_view.code}));
    @(posedge clk);
    err_req <= 3'b001;
    @(posedge clk);
    err_req <= '0;
    @(posedge clk);
    #1;
    chk("fetch_en", 32'h0, 32'(fetch_enable));
    rd(`CTX_SET_OFFSET, 32'h4800_884E);
    wr(`CTX_CLEAR_OFFSET, 32'h0000_8000);
    rd(`CTX_SET_OFFSET, 32'h4800_004E);
    $display("t_run done");
  endtask : t_run

  task automatic t_fill;
    logic [2:0] w;
    logic [2:0] e;
    wr(`CTX_CLEAR_OFFSET, 32'hFFFF_FFFF);
    wr(`CTX_SET_OFFSET, 32'h9000_8000);
    pkt(6'h09, `SPEED_200, 4'b0100, 1'b0, w, e);
    chk("fill_wr", 32'h4, 32'(w));
    chk("fill_end", 32'h2, 32'(e));
    chk("fill_code", {`SPEED_200, `ACK_COMPLETE}, 32'({ctrl_view.speed, ctrl_view.code}));
    pkt(6'h03, `SPEED_200, '0, 1'b0, w, e);
    chk("masked_wr", 32'h0, 32'({w, e}));
    @(posedge clk);
    buf_full <= 1'b1;
    @(posedge clk);
    buf_full <= 1'b0;
    #1;
    chk("full_close", 32'h1, 32'(buf_close));
    $display("t_fill done");
  endtask : t_fill

  task automatic t_ppb;
    logic [2:0] w;
    logic [2:0] e;
    pkt_status_type st[5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
    logic [4:0] cd[5] = '{`EVT_LONG_PACKET, `EVT_OVERRUN, `ACK_DATA_ERROR, `ACK_DATA_ERROR,
      `ACK_COMPLETE};
    wr(`CTX_CLEAR_OFFSET, 32'h0000_8000);
    wr(`CTX_CLEAR_OFFSET, 32'hFFFF_FFFF);
    wr(`CTX_SET_OFFSET, 32'h0000_8000);
    for (int i = 0; i < 5; i++) begin
      pkt(6'h05, 3'(i % 3), st[i], 1'b0, w, e);
      chk("ppb_end", 32'h5, 32'(e));
      chk("ppb_code", 32'({3'(i % 3), cd[i]}), 32'({ctrl_view.speed, ctrl_view.code}));
    end
    pkt(6'h06, `SPEED_100, '0, 1'b0, w, e);
    chk("other_ch", 32'h0, 32'(w));
    $display("t_ppb done");
  endtask : t_ppb

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    close_out();
  end

  initial begin
    {rst, reg_wr, reg_rd, cycle_start, pkt_start, pkt_data_valid} = 6'h20;
    {pkt_second_portion, pkt_end, buf_full, fetch_req, slow} = '0;
    {reg_addr, reg_wdata, bus_cycle_number, pkt_channel, pkt_speed} = '0;
    pkt_data = 32'h0000_00A5;
    channel_mask = 64'h0000_0000_0000_0200;
    pkt_status = '0;
    err_req = '0;
    errors = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_run();
    t_fill();
    t_ppb();
    close_out();
  end
endmodule : iso_rx_context_control_bench

// ---- verif/iso_rx_ctx_props.sv ----
`timescale 1ns/1ps
`include "iso_rx_ctx_regs.svh"
module iso_rx_ctx_props
  import iso_rx_ctx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic cycle_start,
  input wire logic [12:0] bus_cycle_number,
  input wire logic [12:0] start_cycle_value,
  input wire logic desc_fetch,
  input wire dma_err_type dma_err,
  input wire ctrl_type ctrl_view
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic clr_run;
  logic set_wake;
  assign clr_run = reg_wr && reg_addr == `CTX_CLEAR_OFFSET && reg_wdata[`RUN_BIT];
  assign set_wake = reg_wr && reg_addr == `CTX_SET_OFFSET && reg_wdata[`WAKE_BIT];
  property p_rsvd;
    reg_rvalid |-> reg_rdata[26:16] == '0 && reg_rdata[14:13] == '0 && reg_rdata[9:8] == '0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits read nonzero");
  property p_split;
    ctrl_view.split |-> !ctrl_view.fill && !ctrl_view.all_ch;
  endproperty
  a_split: assert property (p_split)
    else $error("split mode with fill or all channel");
  property p_split_lock;
    ctrl_view.run || ctrl_view.active |=> $stable(ctrl_view.split);
  endproperty
  a_split_lock: assert property (p_split_lock)
    else $error("split mode changed while busy");
  property p_run_hold;
    !reg_wr |=> $stable(ctrl_view.run);
  endproperty
  a_run_hold: assert property (p_run_hold)
    else $error("run changed without a write");
  property p_wake;
    desc_fetch && !set_wake |=> !ctrl_view.wake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake not cleared by fetch");
  property p_dead;
    ctrl_view.active && dma_err != '0 |=> ctrl_view.dead && !ctrl_view.active;
  endproperty
  a_dead: assert property (p_dead)
    else $error("fatal error did not halt");
  property p_dead_clr;
    clr_run && dma_err == '0 |=> !ctrl_view.dead && !ctrl_view.active;
  endproperty
  a_dead_clr: assert property (p_dead_clr)
    else $error("stop did not clear dead or active");
  property p_cyc;
    ctrl_view.run && ctrl_view.cyc_en && !ctrl_view.active && !ctrl_view.dead && !reg_wr
      && cycle_start && bus_cycle_number == start_cycle_value |=> ctrl_view.active
      && !ctrl_view.cyc_en;
  endproperty
  a_cyc: assert property (p_cyc)
    else $error("cycle match start failed");
  property p_code;
    $changed(ctrl_view.code) && ctrl_view.fill |-> ctrl_view.code inside
      {`ACK_COMPLETE, `EVT_DESCRIPTOR_READ, `EVT_DATA_WRITE, `EVT_UNKNOWN};
  endproperty
  a_code: assert property (p_code)
    else $error("illegal packed fill code");
endmodule : iso_rx_ctx_props

bind iso_rx_context_control iso_rx_ctx_props i_iso_rx_ctx_props (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cycle_start(cycle_start),
  .bus_cycle_number(bus_cycle_number), .start_cycle_value(start_cycle_value),
  .desc_fetch(desc_fetch), .dma_err(dma_err), .ctrl_view(ctrl_view));
